// *** src/tfr_map.svh ***
// Frame bytes, limits, error codes and timing counts of the tag command parser
`ifndef TFR_MAP_SVH
`define TFR_MAP_SVH
`define TFR_HDR_BYTE     8'h02
`define TFR_TERM_BIN     8'h03
`define TFR_LEAD_WORD    8'hAA
`define TFR_TERM_WORD    8'hFF
`define TFR_CMD_FILL     8'h04
`define TFR_CMD_READ     8'h05
`define TFR_SIZE_FILL    16'h0008
`define TFR_SIZE_READ    16'h0007
`define TFR_SIZE_ACK     8'h01
`define TFR_TMO_MIN      16'h0001
`define TFR_TMO_MAX      16'hFFFE
`define TFR_TAG_LAST     16'h07FF
`define TFR_ERR_SYNTAX   8'hE1
`define TFR_ERR_FORMAT   8'hE2
`define TFR_ERR_TMO      8'hE3
`define TFR_BODY_MAX     9
`define TFR_BODY_FILL_W  4'h9
`define TFR_BODY_READ_W  4'h7
`define TFR_FIFO_DEPTH   16
`define TFR_MS_NS        1000000
`define TFR_CLK_NS       25
`define TFR_MS_CYCLES    (`TFR_MS_NS / `TFR_CLK_NS)
`endif

// *** src/tfr_pkg.sv ***
// Types shared by the tag command parser modules
package tfr_pkg;
  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_HDR2  = 4'h1,
    S_SZH   = 4'h2,
    S_SZL   = 4'h3,
    S_BODY  = 4'h4,
    S_TERM  = 4'h5,
    S_CHECK = 4'h6,
    S_TX    = 4'h7,
    S_ACC   = 4'h8,
    S_WAIT  = 4'h9
  } tfr_state_t;
  typedef enum logic [2:0] {
    K_ERR  = 3'h0,
    K_FILL = 3'h1,
    K_RPRE = 3'h2,
    K_RDAT = 3'h3,
    K_TERM = 3'h4
  } tfr_kind_t;
endpackage : tfr_pkg

// *** src/tfr_byte_if.sv ***
// Byte stream with valid and ready between the parser's own modules
`timescale 1ns/10ps
interface tfr_byte_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : tfr_byte_if

// *** src/tfr_fifo.sv ***
// Receive byte FIFO with registered full and empty flags
`timescale 1ns/10ps
module tfr_fifo #(
  parameter int W = 8,
  parameter int D = 16
)
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  tfr_byte_if.src           out
);
  import tfr_pkg::*;
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          wr;
  logic          rd;

  // Flags are flopped so the source sees ready straight from a register
  assign wr = in_valid & in_ready;
  assign rd = out.valid & out.ready;
  assign cnt_d = cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
  assign out.data = mem_q[rp_q];

  // Storage
  always_ff @(posedge clock)
  begin
    if (wr)
      mem_q[wp_q] <= in_data;
  end

  // Pointers, fill level and flags
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q      <= '0;
      rp_q      <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b0;
      out.valid <= 1'b0;
    end
    else
    begin
      wp_q      <= wp_q + AW'(wr);
      rp_q      <= rp_q + AW'(rd);
      cnt_q     <= cnt_d;
      in_ready  <= cnt_d != (AW+1)'(D);
      out.valid <= cnt_d != '0;
    end
  end
endmodule : tfr_fifo

// *** src/tfr_ms_timer.sv ***
// Millisecond down counter that flags an operation timeout
`timescale 1ns/10ps
`include "tfr_map.svh"
module tfr_ms_timer #(
  parameter int MS_CYC = `TFR_MS_CYCLES
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [15:0] ms,
  output logic             expired
);
  import tfr_pkg::*;
  localparam int SW = $clog2(MS_CYC + 1);
  logic [SW-1:0] sub_q;
  logic [15:0]   left_q;
  logic          run_q;

  // Expiry is a level held until the next start
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_q   <= '0;
      left_q  <= '0;
      run_q   <= 1'b0;
      expired <= 1'b0;
    end
    else if (start)
    begin
      sub_q   <= SW'(MS_CYC - 1);
      left_q  <= ms;
      run_q   <= 1'b1;
      expired <= 1'b0;
    end
    else if (run_q)
    begin
      if (sub_q == '0)
      begin
        sub_q  <= SW'(MS_CYC - 1);
        left_q <= left_q - 16'h0001;
        if (left_q == 16'h0001)
        begin
          expired <= 1'b1;
          run_q   <= 1'b0;
        end
      end
      else
        sub_q <= sub_q - SW'(1);
    end
  end
endmodule : tfr_ms_timer

// *** src/tfr_parser.sv ***
// Tag fill and read command parser with response frame builder
`timescale 1ns/10ps
`include "tfr_map.svh"
// What this block does
// - A binary fill frame is header, size 8, code 4, address, length, timeout, fill byte, checksum, 0x03.
// - A finished binary fill answers header, size 1, the echoed code, and the terminator.
// - A fill length of zero fills from the start address to the last tag location.
// - A word fill frame starts 0xAA and the code, fields go high byte first, fill byte padded, ends 0xFFFF.
// - A finished word fill answers 0xAA, the echoed code and the two terminator bytes.
// - Timeouts count milliseconds, lie between 1 and 0xFFFE, and end the operation when they expire.
// - A read with a zero timeout is refused with a syntax error and no tag access.
// - A read that runs past the last tag address is refused with a format error.
// - A read length lies between one byte and the whole tag.
// - In word framing each read byte goes out in the low byte of a word whose high byte is zero.
// - A binary read frame is header, size 7, code 5, address, length, timeout, checksum, terminator.
// - A binary read answer is header, size of one plus the count, echo, data in rising order, terminator.
// - A word read frame is 0xAA and code 5, address, count, timeout, then 0xFFFF.
// - A fill that runs past the last tag byte is refused with an error.
// - A fill with a zero timeout is refused with a syntax error.
module tfr_parser #(
  parameter int MS_CYCLES = `TFR_MS_CYCLES
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic [7:0]       tx_data_q,
  output logic             tx_valid_q,
  input  wire logic        tx_ready,
  output logic             tag_req_q,
  output logic             tag_write_q,
  output logic [15:0]      tag_addr_q,
  output logic [7:0]       tag_wdata_q,
  input  wire logic        tag_ack,
  input  wire logic [7:0]  tag_rdata
);
  import tfr_pkg::*;

  tfr_byte_if  rx ();
  tfr_state_t  st_q;
  tfr_state_t  st_d;
  tfr_state_t  ret_q;
  tfr_state_t  ret_d;
  tfr_kind_t   kind_q;
  tfr_kind_t   ld_kind;
  logic        word_q;
  logic        ck_q;
  logic [15:0] size_q;
  logic [3:0]  cnt_q;
  logic [3:0]  need;
  logic [7:0]  fld_q [`TFR_BODY_MAX];
  logic [7:0]  ob_q [6];
  logic [7:0]  fr [6];
  logic [2:0]  frn;
  logic [2:0]  obn_q;
  logic [2:0]  obi_q;
  logic [7:0]  err_q;
  logic [7:0]  ld_err;
  logic [15:0] addr_q;
  logic [15:0] left_q;
  logic        ld;
  logic        go;
  logic        acc_go;
  logic        take;
  logic        tx_last;
  logic        tmo_exp;
  logic [7:0]  d;
  logic [7:0]  cmd;
  logic        is_fill;
  logic        cmd_ok;
  logic [15:0] f_addr;
  logic [15:0] f_len;
  logic [15:0] f_tmo;
  logic [7:0]  f_fill;
  logic [7:0]  f_pad;
  logic [16:0] end17;
  logic [15:0] eff_len;
  logic        bad_syn;
  logic        bad_fmt;

  // Receive bytes wait in the FIFO while the parser is busy, so the host is throttled
  tfr_fifo #(
    .W (8),
    .D (`TFR_FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .rst_n    (rst_n),
    .in_data  (rx_data),
    .in_valid (rx_valid),
    .in_ready (rx_ready),
    .out      (rx.src)
  );

  tfr_ms_timer #(
    .MS_CYC (MS_CYCLES)
  ) u_tmr (
    .clock   (clock),
    .rst_n   (rst_n),
    .start   (go),
    .ms      (f_tmo),
    .expired (tmo_exp)
  );

  // Bytes are only pulled while a frame is being parsed
  assign rx.ready = st_q inside {S_IDLE, S_HDR2, S_SZH, S_SZL, S_BODY, S_TERM};
  assign take     = rx.valid & rx.ready;
  assign d        = rx.data;
  assign tx_last  = tx_valid_q & tx_ready & (obi_q + 3'h1 == obn_q);

  // Field views: both framings land the code at 0 and address, length, timeout at 1..6
  assign cmd     = fld_q[0];
  assign is_fill = cmd == `TFR_CMD_FILL;
  assign cmd_ok  = is_fill | (cmd == `TFR_CMD_READ);
  assign f_addr  = {fld_q[1], fld_q[2]};
  assign f_len   = {fld_q[3], fld_q[4]};
  assign f_tmo   = {fld_q[5], fld_q[6]};
  assign f_fill  = word_q ? fld_q[8] : fld_q[7];
  assign f_pad   = word_q ? fld_q[7] : 8'h00;
  assign end17   = {1'b0, f_addr} + {1'b0, f_len} - 17'h0_0001;
  assign eff_len = (is_fill && f_len == 16'h0000) ? `TFR_TAG_LAST - f_addr + 16'h0001 : f_len;
  assign need    = word_q ? (((cnt_q == 4'h0) ? d : cmd) == `TFR_CMD_FILL ? `TFR_BODY_FILL_W
                                                                          : `TFR_BODY_READ_W)
                          : size_q[3:0];

  // Syntax covers frame size, timeout range and word padding
  assign bad_syn = (!word_q && size_q != (is_fill ? `TFR_SIZE_FILL : `TFR_SIZE_READ))
                 || f_tmo < `TFR_TMO_MIN || f_tmo > `TFR_TMO_MAX
                 || (word_q && is_fill && f_pad != 8'h00);
  // Range runs past the tag end, or a read asks for nothing
  assign bad_fmt = f_addr > `TFR_TAG_LAST
                 || (f_len != 16'h0000 && end17 > {1'b0, `TFR_TAG_LAST})
                 || (!is_fill && f_len == 16'h0000);

  // Next state and which response frame to load
  always_comb
  begin
    st_d    = st_q;
    ret_d   = ret_q;
    ld      = 1'b0;
    ld_kind = K_TERM;
    ld_err  = 8'h00;
    go      = 1'b0;
    acc_go  = 1'b0;
    unique case (st_q)
      S_IDLE:
        if (take)
        begin
          if (d == `TFR_HDR_BYTE)
            st_d = S_HDR2;
          else if (d == `TFR_LEAD_WORD)
            st_d = S_BODY;
        end
      S_HDR2:
        if (take)
          st_d = (d == `TFR_HDR_BYTE) ? S_SZH : S_IDLE;
      S_SZH:
        if (take)
          st_d = S_SZL;
      S_SZL:
        if (take)
          st_d = (size_q[15:8] == 8'h00 && d != 8'h00 && d <= 8'(`TFR_BODY_MAX)) ? S_BODY : S_IDLE;
      S_BODY:
        if (take)
        begin
          if (word_q && cnt_q == 4'h0 && d != `TFR_CMD_FILL && d != `TFR_CMD_READ)
            st_d = S_IDLE;
          else if (cnt_q + 4'h1 == need)
            st_d = S_TERM;
        end
      S_TERM:
        if (take)
        begin
          if (word_q)
            st_d = (d != `TFR_TERM_WORD) ? S_IDLE : (ck_q ? S_CHECK : S_TERM);
          else if (d == `TFR_TERM_BIN)
            st_d = S_CHECK;
          else
            st_d = ck_q ? S_IDLE : S_TERM;
        end
      S_CHECK:
      begin
        if (!cmd_ok)
          st_d = S_IDLE;
        else if (bad_syn || bad_fmt)
        begin
          st_d    = S_TX;
          ret_d   = S_IDLE;
          ld      = 1'b1;
          ld_kind = K_ERR;
          ld_err  = bad_syn ? `TFR_ERR_SYNTAX : `TFR_ERR_FORMAT;
        end
        else
        begin
          go = 1'b1;
          if (is_fill)
            st_d = S_ACC;
          else
          begin
            st_d    = S_TX;
            ret_d   = S_ACC;
            ld      = 1'b1;
            ld_kind = K_RPRE;
          end
        end
      end
      S_ACC:
      begin
        if (tmo_exp || left_q == 16'h0000)
        begin
          st_d    = S_TX;
          ret_d   = S_IDLE;
          ld      = 1'b1;
          ld_kind = !is_fill ? K_TERM : (tmo_exp ? K_ERR : K_FILL);
          ld_err  = `TFR_ERR_TMO;
        end
        else
        begin
          acc_go = 1'b1;
          st_d   = S_WAIT;
        end
      end
      S_WAIT:
        if (tag_ack)
        begin
          if (is_fill)
            st_d = S_ACC;
          else
          begin
            st_d    = S_TX;
            ret_d   = S_ACC;
            ld      = 1'b1;
            ld_kind = K_RDAT;
          end
        end
        else if (tmo_exp)
          st_d = S_ACC;
      S_TX:
        if (tx_last)
          st_d = ret_q;
      default:
        st_d = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q  <= S_IDLE;
      ret_q <= S_IDLE;
    end
    else
    begin
      st_q  <= st_d;
      ret_q <= ret_d;
    end
  end

  // Frame capture: mode, size, body bytes and the checksum or first terminator mark
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_q <= 1'b0;
      ck_q   <= 1'b0;
      size_q <= 16'h0000;
      cnt_q  <= 4'h0;
      for (int i = 0; i < `TFR_BODY_MAX; i++)
        fld_q[i] <= 8'h00;
    end
    else if (take)
    begin
      unique case (st_q)
        S_IDLE:
        begin
          word_q <= d == `TFR_LEAD_WORD;
          cnt_q  <= 4'h0;
          ck_q   <= 1'b0;
          for (int i = 0; i < `TFR_BODY_MAX; i++)
            fld_q[i] <= 8'h00;
        end
        S_SZH:
          size_q[15:8] <= d;
        S_SZL:
          size_q[7:0] <= d;
        S_BODY:
        begin
          fld_q[cnt_q] <= d;
          cnt_q        <= cnt_q + 4'h1;
        end
        S_TERM:
          ck_q <= 1'b1; // A stray byte before the terminator is the optional checksum
        default:
          ck_q <= ck_q;
      endcase
    end
  end

  // Response frames; read data is streamed so no tag-sized buffer is needed
  always_comb
  begin
    for (int i = 0; i < 6; i++)
      fr[i] = 8'h00;
    frn = 3'h1;
    unique case (ld_kind)
      K_ERR, K_FILL:
      begin
        if (word_q)
        begin
          fr[0] = `TFR_LEAD_WORD;
          fr[1] = (ld_kind == K_FILL) ? cmd : ld_err;
          fr[2] = `TFR_TERM_WORD;
          fr[3] = `TFR_TERM_WORD;
          frn   = 3'h4;
        end
        else
        begin
          fr[0] = `TFR_HDR_BYTE;
          fr[1] = `TFR_HDR_BYTE;
          fr[3] = `TFR_SIZE_ACK;
          fr[4] = (ld_kind == K_FILL) ? cmd : ld_err;
          fr[5] = `TFR_TERM_BIN;
          frn   = 3'h6;
        end
      end
      K_RPRE:
      begin
        if (word_q)
        begin
          fr[0] = `TFR_LEAD_WORD;
          fr[1] = cmd;
          frn   = 3'h2;
        end
        else
        begin
          fr[0]      = `TFR_HDR_BYTE;
          fr[1]      = `TFR_HDR_BYTE;
          {fr[2], fr[3]} = f_len + 16'h0001;
          fr[4]      = cmd;
          frn        = 3'h5;
        end
      end
      K_RDAT:
      begin
        fr[0] = word_q ? 8'h00 : tag_rdata;
        fr[1] = tag_rdata;
        frn   = word_q ? 3'h2 : 3'h1;
      end
      K_TERM:
      begin
        fr[0] = word_q ? `TFR_TERM_WORD : `TFR_TERM_BIN;
        fr[1] = `TFR_TERM_WORD;
        frn   = word_q ? 3'h2 : 3'h1;
      end
      default:
        frn = 3'h1;
    endcase
  end

  // Transmit byte sequencer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_data_q  <= 8'h00;
      tx_valid_q <= 1'b0;
      obn_q      <= 3'h0;
      obi_q      <= 3'h0;
      kind_q     <= K_TERM;
      err_q      <= 8'h00;
      for (int i = 0; i < 6; i++)
        ob_q[i] <= 8'h00;
    end
    else if (ld)
    begin
      ob_q       <= fr;
      obn_q      <= frn;
      obi_q      <= 3'h0;
      kind_q     <= ld_kind;
      err_q      <= (ld_kind == K_ERR) ? ld_err : 8'h00;
      tx_data_q  <= fr[0];
      tx_valid_q <= 1'b1;
    end
    else if (tx_valid_q && tx_ready)
    begin
      obi_q      <= obi_q + 3'h1;
      tx_valid_q <= !tx_last;
      tx_data_q  <= ob_q[3'(obi_q + 3'h1)];
    end
  end

  // Tag access walk, one byte per request and acknowledge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tag_req_q   <= 1'b0;
      tag_write_q <= 1'b0;
      tag_addr_q  <= 16'h0000;
      tag_wdata_q <= 8'h00;
      addr_q      <= 16'h0000;
      left_q      <= 16'h0000;
    end
    else if (go)
    begin
      addr_q      <= f_addr;
      left_q      <= eff_len;
      tag_write_q <= is_fill;
      tag_wdata_q <= f_fill;
    end
    else if (acc_go)
    begin
      tag_req_q  <= 1'b1;
      tag_addr_q <= addr_q;
    end
    else if (st_q == S_WAIT && (tag_ack || tmo_exp))
    begin
      tag_req_q <= 1'b0;
      if (tag_ack)
      begin
        addr_q <= addr_q + 16'h0001;
        left_q <= left_q - 16'h0001;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_first_byte;
    st_q == S_IDLE && take && d != `TFR_HDR_BYTE && d != `TFR_LEAD_WORD |=> st_q == S_IDLE;
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("stray lead byte not dropped");
  property p_fill_size;
    st_q == S_CHECK && !word_q && is_fill && size_q != `TFR_SIZE_FILL
      |=> st_q == S_TX && err_q == `TFR_ERR_SYNTAX && !tag_req_q;
  endproperty
  a_fill_size: assert property (p_fill_size) else $error("bad fill size accepted");
  property p_read_size;
    st_q == S_CHECK && !word_q && cmd == `TFR_CMD_READ && size_q != `TFR_SIZE_READ |=> err_q == `TFR_ERR_SYNTAX;
  endproperty
  a_read_size: assert property (p_read_size) else $error("bad read size accepted");
  property p_read_tmo0;
    st_q == S_CHECK && cmd == `TFR_CMD_READ && f_tmo == 16'h0000
      |=> err_q == `TFR_ERR_SYNTAX ##1 !tag_req_q [*3];
  endproperty
  a_read_tmo0: assert property (p_read_tmo0) else $error("zero read timeout not refused");
  property p_fill_tmo0;
    st_q == S_CHECK && is_fill && f_tmo == 16'h0000 |=> kind_q == K_ERR && err_q == `TFR_ERR_SYNTAX;
  endproperty
  a_fill_tmo0: assert property (p_fill_tmo0) else $error("zero fill timeout not refused");
  property p_read_range;
    st_q == S_CHECK && cmd == `TFR_CMD_READ && !bad_syn && end17 > {1'b0, `TFR_TAG_LAST}
      |=> err_q == `TFR_ERR_FORMAT;
  endproperty
  a_read_range: assert property (p_read_range) else $error("read past tag end accepted");
  property p_read_len0;
    st_q == S_CHECK && cmd == `TFR_CMD_READ && !bad_syn && f_len == 16'h0000 |=> kind_q == K_ERR;
  endproperty
  a_read_len0: assert property (p_read_len0) else $error("empty read accepted");
  property p_fill_all;
    st_q == S_CHECK && is_fill && !bad_syn && !bad_fmt && f_len == 16'h0000
      |=> left_q == `TFR_TAG_LAST - $past(f_addr) + 16'h0001;
  endproperty
  a_fill_all: assert property (p_fill_all) else $error("zero fill length not to tag end");
  property p_word_hi0;
    st_q == S_TX && kind_q == K_RDAT && word_q && obi_q == 3'h0 && tx_valid_q |-> tx_data_q == 8'h00;
  endproperty
  a_word_hi0: assert property (p_word_hi0) else $error("word read high byte not zero");
  property p_bin_ack;
    $rose(tx_valid_q) && kind_q == K_FILL && !word_q |-> ob_q[2] == 8'h00 && ob_q[3] == `TFR_SIZE_ACK
      && ob_q[4] == `TFR_CMD_FILL && ob_q[5] == `TFR_TERM_BIN;
  endproperty
  a_bin_ack: assert property (p_bin_ack) else $error("binary fill reply malformed");
  property p_word_ack;
    $rose(tx_valid_q) && kind_q == K_FILL && word_q |-> tx_data_q == `TFR_LEAD_WORD && ob_q[1] == `TFR_CMD_FILL;
  endproperty
  a_word_ack: assert property (p_word_ack) else $error("word fill reply malformed");
  property p_tmo_end;
    st_q == S_ACC && tmo_exp |=> st_q == S_TX && ret_q == S_IDLE && !tag_req_q;
  endproperty
  a_tmo_end: assert property (p_tmo_end) else $error("timeout did not end operation");
  property p_read_hdr;
    $rose(tx_valid_q) && kind_q == K_RPRE && !word_q |-> {ob_q[2], ob_q[3]} == $past(f_len) + 16'h0001;
  endproperty
  a_read_hdr: assert property (p_read_hdr) else $error("read reply size wrong");
endmodule : tfr_parser

// *** bench/tfr_tag_model.sv ***
// Tag memory stand-in that answers the parser's byte requests
`timescale 1ns/10ps
module tfr_tag_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [3:0]  lat,
  output logic             ack,
  output logic [7:0]       rdata
);
  logic [7:0] mem [2048];
  logic [3:0] cnt_q;
  // Distinct pattern so a wrong address shows up in read data
  initial
  begin
    for (int i = 0; i < 2048; i++)
      mem[i] = 8'(i) ^ 8'h5A;
  end
  // One ack per request after lat cycles; rdata churns when not valid
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 4'h0;
      ack <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      ack <= req && !ack && cnt_q == lat;
      cnt_q <= (req && !ack) ? cnt_q + 4'h1 : 4'h0;
      rdata <= ~rdata;
      if (req && !ack && cnt_q == lat)
      begin
        rdata <= mem[addr[10:0]];
        if (wr)
          mem[addr[10:0]] <= wdata;
      end
    end
  end
endmodule : tfr_tag_model

// *** bench/tb_top.sv ***
// Self-checking bench for the tag command parser
`timescale 1ns/10ps
module tb_top;
  logic        clock;
  logic        rst_n;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_ready;
  logic [7:0]  tx_data_q;
  logic        tx_valid_q;
  logic        tx_ready;
  logic        tag_req_q;
  logic        tag_write_q;
  logic [15:0] tag_addr_q;
  logic [7:0]  tag_wdata_q;
  logic        tag_ack;
  logic [7:0]  tag_rdata;
  logic [3:0]  lat;
  logic        req_d;
  int          errors;
  int          total_checks;
  int          nreq;

  // Short millisecond keeps timeout runs brief
  tfr_parser #(.MS_CYCLES(4)) u_dut (.clock(clock), .rst_n(rst_n), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q),
    .tx_ready(tx_ready), .tag_req_q(tag_req_q), .tag_write_q(tag_write_q),
    .tag_addr_q(tag_addr_q), .tag_wdata_q(tag_wdata_q), .tag_ack(tag_ack), .tag_rdata(tag_rdata));
  tfr_tag_model u_tag (.clock(clock), .rst_n(rst_n), .req(tag_req_q), .wr(tag_write_q),
    .addr(tag_addr_q), .wdata(tag_wdata_q), .lat(lat), .ack(tag_ack), .rdata(tag_rdata));

  // 40 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Count tag requests by their rising edge
  always @(posedge clock)
  begin
    req_d <= tag_req_q;
    if (tag_req_q === 1'b1 && req_d !== 1'b1)
      nreq++;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  // Frames are hex strings, two digits a byte; each byte held until taken
  task automatic send(input string s);
    int k;
    for (int i = 0; i < s.len() / 2; i++)
    begin
      rx_data = 8'(s.substr(2 * i, 2 * i + 1).atohex());
      rx_valid = 1'b1;
      k = 0;
      do
      begin
        @(posedge clock);
        k++;
      end
      while (rx_ready !== 1'b1 && k < 500);
      #2;
    end
    rx_valid = 1'b0;
  endtask : send

  // Send a frame, collect the answer while stalling every other cycle
  task automatic xfer(input string nm, input string cmd, input string rsp, input int reqs);
    int n;
    int k;
    nreq = 0;
    send(cmd);
    n = 0;
    k = 0;
    while (n < rsp.len() / 2 && k < 20000)
    begin
      @(posedge clock);
      if (tx_valid_q === 1'b1 && tx_ready === 1'b1)
      begin
        check(nm, 16'(tx_data_q), 16'(rsp.substr(2 * n, 2 * n + 1).atohex()));
        n++;
      end
      k++;
      #2 tx_ready = ~tx_ready;
    end
    check({nm, " count"}, 16'(n), 16'(rsp.len() / 2));
    repeat (4) @(posedge clock);
    check({nm, " extra"}, 16'(tx_valid_q), 16'h0000);
    check({nm, " reqs"}, 16'(nreq), 16'(reqs));
    #2;
  endtask : xfer

  // Zero length fills to the end; the checksum byte is accepted unchecked
  task automatic t_bin_fill;
    xfer("bin fill", "020200080407FC0000FFFE419903", "020200010403", 4);
    for (int a = 2043; a < 2048; a++)
      check("fill mem", 16'(u_tag.mem[a]), (a == 2043) ? 16'h00A1 : 16'h0041);
  endtask : t_bin_fill

  // A stray lead byte is dropped before a word fill
  task automatic t_word_fill;
    xfer("word fill", "55AA0407F0000207D00033FFFF", "AA04FFFF", 2);
    check("wfill mem", 16'(u_tag.mem[2032]), 16'h0033);
    check("wfill mem", 16'(u_tag.mem[2033]), 16'h0033);
    check("wfill mem", 16'(u_tag.mem[2034]), 16'h00A8);
  endtask : t_word_fill

  // Reads against a slow tag, both framings
  task automatic t_reads2;
    lat = 4'h3;
    xfer("bin read", "02020007050010000407D003", "02020005054A4B484903", 4);
    xfer("word read", "AA050020000207D0FFFF", "AA05007A007BFFFF", 2);
    lat = 4'h0;
  endtask : t_reads2

  // Refused frames answer an error, except a bad terminator, which drops the frame with no answer; none touch the tag
  task automatic t_refuse;
    xfer("rd tmo0", "020200070500000001000003", "02020001E103", 0);
    xfer("bad term", "AA040000000100000077FF00", "", 0);
    xfer("fill tmo0", "AA040000000100000077FFFF", "AAE1FFFF", 0);
    xfer("fill size", "020200070400000001000103", "02020001E103", 0);
    xfer("read size", "02020008050000000100010003", "02020001E103", 0);
    xfer("tmo max", "AA0500000001FFFFFFFF", "AAE1FFFF", 0);
    xfer("rd range", "020200070507FF000207D003", "02020001E203", 0);
    xfer("rd len0", "AA050000000007D0FFFF", "AAE2FFFF", 0);
    xfer("fill range", "020200080407FE000307D05503", "02020001E203", 0);
  endtask : t_refuse

  // A tag slower than the one millisecond timeout runs the fill into it
  task automatic t_timeout;
    lat = 4'hF;
    xfer("fill tmo", "AA040000000100010077FFFF", "AAE3FFFF", 1);
    check("tmo mem", 16'(u_tag.mem[0]), 16'h005A);
    lat = 4'h0;
  endtask : t_timeout

  // A reset in mid-frame idles the outputs and framing restarts at the next lead byte
  task automatic t_reset;
    send("AA0500");
    rst_n = 1'b0;
    #2;
    check("rst rx_ready", 16'(rx_ready), 16'h0000);
    check("rst tx_valid", 16'(tx_valid_q), 16'h0000);
    check("rst tag_req", 16'(tag_req_q), 16'h0000);
    repeat (2) @(posedge clock);
    #2 rst_n = 1'b1;
    @(posedge clock);
    #2;
    check("rst rx_ready up", 16'(rx_ready), 16'h0001);
    xfer("after rst", "AA050000000007D0FFFF", "AAE2FFFF", 0);
  endtask : t_reset

  // Watchdog well beyond the longest expected run
  initial
  begin
    #(25 * 60000);
    errors++;
    results();
  end

  initial
  begin
    rst_n = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
    lat = 4'h0;
    errors = 0;
    total_checks = 0;
    nreq = 0;
    repeat (12) @(posedge clock);
    #2 rst_n = 1'b1;
    repeat (2) @(posedge clock);
    #2;
    t_bin_fill();
    t_word_fill();
    t_reads2();
    t_refuse();
    t_timeout();
    t_reset();
    results();
  end
endmodule : tb_top
